// ---- omsc_top.sv ----
// top of the optical module control block with two-wire status access
`timescale 1ns/1ps
`default_nettype none
`include "omsc_regs.svh"
// Function
// - laser-off high turns the transmitter off, low allows normal transmission.
// - a floating laser-off input counts as disable; laser stays off.
// - cycling the laser-off input clears the fault state, eye-safety trips included.
// - catastrophic laser failure disables the laser and raises the fault output.
// - fault output low in normal operation, high when a fault exists.
// - fault stays latched until laser-off toggles or power is cycled.
// - fault state appears in bit 2 of status byte 110.
// - eye-safety monitor trip disables the transmitter and raises fault.
// - loss-of-signal output low with usable light, high without it.
// - loss-of-signal state appears in bit 1 of status byte 110.
// - diagnostic page of 256 bytes served at two-wire address 0xA2.
module omsc_top
    import omsc_pkg::*;
(
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic tx_disable_pin,
    input  wire logic laser_fail_in,
    input  wire logic eye_unsafe_in,
    input  wire logic light_lost_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    output logic      laser_enable,
    output logic      laser_fault_out,
    output logic      laser_fault_oe,
    output logic      input_light_missing_pin
);
    omsc_tx_if    tx_bus ();
    omsc_top_st_t st_r;
    omsc_top_st_t st_nxt;
    logic [2:0]   ctl_s;
    logic [2:0]   mon_s;
    logic         scl_s;
    logic         sda_s;
    logic         scl_rise;
    logic         scl_fall;
    logic         start_c;
    logic         stop_c;
    logic [7:0]   status_byte;
    logic [7:0]   rd_byte;

    // disable, clock and data idle high so an open pin reads as disable
    omsc_sync #(.W(3), .RST(`OMSC_CTL_PIN_RST)) u_ctl_sync
    (
        .clock  (clock),
        .arst_n (arst_n),
        .d      ({tx_disable_pin, scl_in, sda_in}),
        .q      (ctl_s)
    );

    omsc_sync #(.W(3), .RST(`OMSC_MON_PIN_RST)) u_mon_sync
    (
        .clock  (clock),
        .arst_n (arst_n),
        .d      ({laser_fail_in, eye_unsafe_in, light_lost_in}),
        .q      (mon_s)
    );

    assign tx_bus.disable_s    = ctl_s[2];
    assign tx_bus.laser_fail_s = mon_s[2];
    assign tx_bus.eye_unsafe_s = mon_s[1];
    assign scl_s               = ctl_s[1];
    assign sda_s               = ctl_s[0];

    omsc_tx_ctrl u_tx_ctrl
    (
        .clock  (clock),
        .arst_n (arst_n),
        .tx     (tx_bus)
    );

    // status carries the latched fault state and the registered loss-of-signal state
    always_comb
    begin
        status_byte                 = `OMSC_STATUS_RST;
        status_byte[`OMSC_FAULT_BIT] = tx_bus.fault;
        status_byte[`OMSC_LOS_BIT]   = st_r.input_light_missing;
    end

    // only the status byte is populated; the rest of the page reads zero
    assign rd_byte = (st_r.ptr == `OMSC_STATUS_OFS) ? status_byte : 8'h00;

    assign scl_rise = scl_s && !st_r.scl_p;
    assign scl_fall = !scl_s && st_r.scl_p;
    assign start_c  = scl_s && st_r.scl_p && st_r.sda_p && !sda_s;
    assign stop_c   = scl_s && st_r.scl_p && !st_r.sda_p && sda_s;

    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.scl_p = scl_s;
        st_nxt.sda_p = sda_s;
        st_nxt.input_light_missing   = mon_s[0];
        if (start_c)
        begin
            st_nxt.state  = OMSC_RX;
            st_nxt.kind   = OMSC_K_ADDR;
            st_nxt.cnt    = 3'h0;
            st_nxt.done   = 1'b0;
            st_nxt.sda_oe = 1'b0;
        end
        else if (stop_c)
        begin
            st_nxt.state  = OMSC_IDLE;
            st_nxt.sda_oe = 1'b0;
        end
        else
        begin
            unique case (st_r.state)
                OMSC_IDLE:
                begin
                    st_nxt.sda_oe = 1'b0;
                end
                OMSC_RX:
                begin
                    if (scl_rise)
                    begin
                        st_nxt.sh  = {st_r.sh[6:0], sda_s};
                        st_nxt.cnt = st_r.cnt + 3'h1;
                        if (st_r.cnt == 3'h7)
                            st_nxt.done = 1'b1;
                    end
                    else if (scl_fall && st_r.done)
                    begin
                        st_nxt.done = 1'b0;
                        unique case (st_r.kind)
                            OMSC_K_ADDR:
                            begin
                                if (st_r.sh[7:1] == `OMSC_DEV_ADDR7)
                                begin
                                    st_nxt.rw     = st_r.sh[0];
                                    st_nxt.sda_oe = 1'b1;
                                    st_nxt.state  = OMSC_ACK;
                                end
                                else
                                begin
                                    st_nxt.state = OMSC_IDLE;
                                end
                            end
                            OMSC_K_OFFS:
                            begin
                                st_nxt.ptr    = st_r.sh;
                                st_nxt.sda_oe = 1'b1;
                                st_nxt.state  = OMSC_ACK;
                            end
                            default:
                            begin
                                // page is read-only: written data is dropped
                                st_nxt.ptr    = st_r.ptr + 8'h01;
                                st_nxt.sda_oe = 1'b1;
                                st_nxt.state  = OMSC_ACK;
                            end
                        endcase
                    end
                end
                OMSC_ACK:
                begin
                    if (scl_fall)
                    begin
                        st_nxt.cnt = 3'h0;
                        if (st_r.kind == OMSC_K_ADDR && st_r.rw)
                        begin
                            st_nxt.sh     = rd_byte;
                            st_nxt.ptr    = st_r.ptr + 8'h01;
                            st_nxt.sda_oe = !rd_byte[7];
                            st_nxt.state  = OMSC_TX;
                        end
                        else
                        begin
                            st_nxt.sda_oe = 1'b0;
                            st_nxt.kind   = (st_r.kind == OMSC_K_ADDR) ?
                                            OMSC_K_OFFS : OMSC_K_WDATA;
                            st_nxt.state  = OMSC_RX;
                        end
                    end
                end
                OMSC_TX:
                begin
                    if (scl_fall)
                    begin
                        st_nxt.cnt = st_r.cnt + 3'h1;
                        if (st_r.cnt == 3'h7)
                        begin
                            st_nxt.sda_oe = 1'b0;
                            st_nxt.cont   = 1'b0;
                            st_nxt.state  = OMSC_RACK;
                        end
                        else
                        begin
                            st_nxt.sh     = {st_r.sh[6:0], 1'b0};
                            st_nxt.sda_oe = !st_r.sh[6];
                        end
                    end
                end
                OMSC_RACK:
                begin
                    if (scl_rise)
                    begin
                        st_nxt.cont = !sda_s;
                        if (sda_s)
                            st_nxt.state = OMSC_IDLE;
                    end
                    else if (scl_fall && st_r.cont)
                    begin
                        st_nxt.cnt    = 3'h0;
                        st_nxt.sh     = rd_byte;
                        st_nxt.ptr    = st_r.ptr + 8'h01;
                        st_nxt.sda_oe = !rd_byte[7];
                        st_nxt.state  = OMSC_TX;
                    end
                end
                default:
                begin
                    st_nxt.state  = OMSC_IDLE;
                    st_nxt.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            st_r <= '{state: OMSC_IDLE, kind: OMSC_K_ADDR, cnt: 3'h0, sh: 8'h00,
                      ptr: 8'h00, rw: 1'b0, done: 1'b0, cont: 1'b0,
                      sda_oe: 1'b0, scl_p: 1'b1, sda_p: 1'b1, input_light_missing: 1'b0};
        else
            st_r <= st_nxt;
    end

    assign sda_out                 = 1'b0;
    assign sda_oe                  = st_r.sda_oe;
    assign laser_enable            = tx_bus.laser_on;
    // open collector: pulled low in normal operation, released on fault
    assign laser_fault_out         = 1'b0;
    assign laser_fault_oe          = !tx_bus.fault;
    assign input_light_missing_pin = st_r.input_light_missing;
endmodule : omsc_top
`default_nettype wire

// ---- omsc_regs.svh ----
// constants for the optical module transmit control and status block
`ifndef OMSC_REGS_SVH
`define OMSC_REGS_SVH
`define OMSC_DEV_ADDR7    7'h51
`define OMSC_STATUS_OFS   8'h6E
`define OMSC_FAULT_BIT    2
`define OMSC_LOS_BIT      1
`define OMSC_STATUS_RST   8'h00
`define OMSC_CTL_PIN_RST  3'h7
`define OMSC_MON_PIN_RST  3'h0
`endif

// ---- omsc_pkg.sv ----
// types for the optical module transmit control and status block
package omsc_pkg;
    typedef enum logic [4:0] {
        OMSC_IDLE = 5'h01,
        OMSC_RX   = 5'h02,
        OMSC_ACK  = 5'h04,
        OMSC_TX   = 5'h08,
        OMSC_RACK = 5'h10
    } omsc_state_t;

    typedef enum logic [1:0] {
        OMSC_K_ADDR  = 2'h0,
        OMSC_K_OFFS  = 2'h1,
        OMSC_K_WDATA = 2'h2
    } omsc_kind_t;

    typedef struct packed {
        omsc_state_t state;
        omsc_kind_t  kind;
        logic [2:0]  cnt;
        logic [7:0]  sh;
        logic [7:0]  ptr;
        logic        rw;
        logic        done;
        logic        cont;
        logic        sda_oe;
        logic        scl_p;
        logic        sda_p;
        logic        input_light_missing;
    } omsc_top_st_t;

    typedef struct packed {
        logic dis_p;
        logic fault;
        logic laser_on;
    } omsc_tx_st_t;
endpackage : omsc_pkg

// ---- omsc_tx_if.sv ----
// carrier between the top and the transmit control module
`timescale 1ns/1ps
`default_nettype none
interface omsc_tx_if;
    logic disable_s;
    logic laser_fail_s;
    logic eye_unsafe_s;
    logic laser_on;
    logic fault;
    modport ctrl (input disable_s, input laser_fail_s, input eye_unsafe_s,
                  output laser_on, output fault);
    modport top  (output disable_s, output laser_fail_s, output eye_unsafe_s,
                  input laser_on, input fault);
endinterface : omsc_tx_if
`default_nettype wire

// ---- omsc_sync.sv ----
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module omsc_sync
    import omsc_pkg::*;
#(
    parameter int             W   = 3,
    parameter logic [W-1:0]   RST = '0
)(
    input  wire logic         clock,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } omsc_sync_st_t;

    omsc_sync_st_t st_r;
    omsc_sync_st_t st_nxt;

    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            st_r <= '{s1: RST, s2: RST};
        else
            st_r <= st_nxt;
    end

    assign q = st_r.s2;
endmodule : omsc_sync
`default_nettype wire

// ---- omsc_tx_ctrl.sv ----
// transmit disable handling and latched laser fault
`timescale 1ns/1ps
`default_nettype none
module omsc_tx_ctrl
    import omsc_pkg::*;
(
    input  wire logic clock,
    input  wire logic arst_n,
    omsc_tx_if.ctrl   tx
);
    omsc_tx_st_t st_r;
    omsc_tx_st_t st_nxt;
    logic        dis_rise;
    logic        fault_src;

    always_comb
    begin
        st_nxt    = st_r;
        dis_rise  = tx.disable_s && !st_r.dis_p;
        fault_src = tx.laser_fail_s || tx.eye_unsafe_s;
        st_nxt.dis_p = tx.disable_s;
        // a fault source in the same cycle as the toggle keeps the fault
        if (fault_src)
            st_nxt.fault = 1'b1;
        else if (dis_rise)
            st_nxt.fault = 1'b0;
        st_nxt.laser_on = !tx.disable_s && !st_nxt.fault && !fault_src;
    end

    // power cycle (reset) also clears the fault
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            st_r <= '{dis_p: 1'b1, fault: 1'b0, laser_on: 1'b0};
        else
            st_r <= st_nxt;
    end

    assign tx.laser_on = st_r.laser_on;
    assign tx.fault    = st_r.fault;
endmodule : omsc_tx_ctrl
`default_nettype wire

// ---- omsc_top_monitor.sv ----
// pin level checks for the optical module control block
`timescale 1ns/1ps
`default_nettype none
module omsc_top_monitor (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic tx_disable_pin,
    input wire logic laser_fail_in,
    input wire logic eye_unsafe_in,
    input wire logic light_lost_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic laser_enable,
    input wire logic laser_fault_out,
    input wire logic laser_fault_oe,
    input wire logic input_light_missing_pin
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    chk_fail_raise: assert property (laser_fail_in[*3] |=> !laser_fault_oe && !laser_enable)
        else $error("laser failure did not raise fault");
    chk_eye_raise: assert property (eye_unsafe_in[*3] |=> !laser_fault_oe && !laser_enable)
        else $error("eye trip did not raise fault");
    chk_fault_hold: assert property ((!tx_disable_pin)[*4] ##0 !laser_fault_oe |=> !laser_fault_oe)
        else $error("fault released without toggle");
    chk_toggle_clear: assert property (!tx_disable_pin ##1
        (tx_disable_pin && !laser_fail_in && !eye_unsafe_in)[*4] |=> laser_fault_oe)
        else $error("toggle did not clear fault");
    chk_laser_allow: assert property ((!tx_disable_pin && !laser_fail_in && !eye_unsafe_in
        && laser_fault_oe)[*4] |=> laser_enable)
        else $error("laser not enabled");
    chk_disable_off: assert property (tx_disable_pin[*3] |=> !laser_enable)
        else $error("laser on while disabled");
    chk_fault_gate: assert property (!laser_fault_oe |-> !laser_enable)
        else $error("laser on during fault");
    chk_los_high: assert property (light_lost_in[*3] |=> input_light_missing_pin)
        else $error("loss output not high");
    chk_los_low: assert property ((!light_lost_in)[*3] |=> !input_light_missing_pin)
        else $error("loss output not low");
    chk_sda_steady: assert property (scl_in[*4] |=> $stable(sda_oe))
        else $error("data changed while clock high");
    cov_fault: cover property (!laser_fault_oe ##1 laser_fault_oe);
    cov_los: cover property ($rose(input_light_missing_pin));
    cov_ack: cover property (sda_oe && scl_in);
endmodule : omsc_top_monitor
bind omsc_top omsc_top_monitor omsc_top_monitor_inst (.clock(clock), .arst_n(arst_n),
    .tx_disable_pin(tx_disable_pin), .laser_fail_in(laser_fail_in),
    .eye_unsafe_in(eye_unsafe_in), .light_lost_in(light_lost_in), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .laser_enable(laser_enable),
    .laser_fault_out(laser_fault_out), .laser_fault_oe(laser_fault_oe),
    .input_light_missing_pin(input_light_missing_pin));
`default_nettype wire

// ---- omsc_host_model.sv ----
// host board wiring: pull-ups and the open laser-off pin
`timescale 1ns/1ps
`default_nettype none
module omsc_host_model (
    input  wire logic dis_drv,
    input  wire logic dis_open,
    input  wire logic scl_m,
    input  wire logic sda_m,
    input  wire logic sda_oe,
    input  wire logic laser_fault_oe,
    output logic      tx_disable_pin,
    output logic      scl_in,
    output logic      sda_in,
    output logic      fault_wire
);
    // an open pin reads high; a host not using it drives low; spacing left to the bench
    assign tx_disable_pin = dis_open ? 1'b1 : dis_drv;
    assign scl_in         = scl_m;
    assign sda_in         = sda_m & ~sda_oe;
    assign fault_wire     = ~laser_fault_oe;
endmodule : omsc_host_model
`default_nettype wire

// ---- test_optical_module_tx_control_status.sv ----
// self-checking bench for the optical module control block
`timescale 1ns/1ps
`default_nettype none
module test_optical_module_tx_control_status;
    logic clock, arst_n, dis_drv, dis_open, scl_m, sda_m;
    logic laser_fail_in, eye_unsafe_in, light_lost_in;
    logic tx_disable_pin, scl_in, sda_in, fault_wire, sda_out, sda_oe;
    logic laser_enable, laser_fault_out, laser_fault_oe, input_light_missing_pin;
    int   n_errors, check_count;
    logic [7:0] v;
    logic       k;
    omsc_host_model omsc_host_model_inst (.dis_drv(dis_drv), .dis_open(dis_open),
        .scl_m(scl_m), .sda_m(sda_m), .sda_oe(sda_oe), .laser_fault_oe(laser_fault_oe),
        .tx_disable_pin(tx_disable_pin), .scl_in(scl_in), .sda_in(sda_in),
        .fault_wire(fault_wire));
    omsc_top omsc_top_inst (.clock(clock), .arst_n(arst_n), .tx_disable_pin(tx_disable_pin),
        .laser_fail_in(laser_fail_in), .eye_unsafe_in(eye_unsafe_in),
        .light_lost_in(light_lost_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe(sda_oe), .laser_enable(laser_enable), .laser_fault_out(laser_fault_out),
        .laser_fault_oe(laser_fault_oe), .input_light_missing_pin(input_light_missing_pin));
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // nine bits wide so the acknowledge flag travels with the read byte
    task check(input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task close_out;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out
    task ph(input int n);
        repeat (n) @(negedge clock);
    endtask : ph
    // one bus bit: data set while clock low, sampled mid high phase
    task bitx(input logic b, output logic r);
        sda_m = b;
        ph(8);
        scl_m = 1'b1;
        ph(4);
        r = sda_in;
        ph(4);
        scl_m = 1'b0;
    endtask : bitx
    task bytex(input logic [7:0] d, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r[i]);
        bitx(1'b1, a);
    endtask : bytex
    task start_c;
        sda_m = 1'b1;
        ph(8);
        scl_m = 1'b1;
        ph(8);
        sda_m = 1'b0;
        ph(8);
        scl_m = 1'b0;
    endtask : start_c
    // offset write, repeated start, one byte read ended by a nack, stop
    task rd(input logic [7:0] wa, input logic [7:0] ofs);
        logic [7:0] x;
        logic       a1, a2, a3;
        start_c;
        bytex(wa, x, a1);
        bytex(ofs, x, a2);
        start_c;
        bytex(wa | 8'h01, x, a3);
        bytex(8'hFF, v, x[0]);
        sda_m = 1'b0;
        ph(8);
        scl_m = 1'b1;
        ph(8);
        sda_m = 1'b1;
        ph(8);
        k = a1 | a2 | a3;
    endtask : rd
    task t_float;
        ph(20);
        check(laser_enable, 1'b0);
        dis_open = 1'b0;
        dis_drv  = 1'b0;
        ph(5);
        check(laser_enable, 1'b1);
        $display("t_float done");
    endtask : t_float
    task t_fault(input logic eye);
        laser_fail_in = !eye;
        eye_unsafe_in = eye;
        ph(5);
        check({laser_enable, fault_wire}, 2'b01);
        laser_fail_in = 1'b0;
        eye_unsafe_in = 1'b0;
        ph(5);
        check({laser_enable, fault_wire}, 2'b01);
        rd(8'hA2, 8'h6E);
        check({k, v}, 9'h004);
        dis_drv = 1'b1;
        ph(5);
        check({laser_enable, fault_wire}, 2'b00);
        dis_drv = 1'b0;
        ph(5);
        check(laser_enable, 1'b1);
        rd(8'hA2, 8'h6E);
        check(v, 8'h00);
        $display("t_fault done");
    endtask : t_fault
    task t_los;
        light_lost_in = 1'b1;
        laser_fail_in = 1'b1;
        ph(5);
        check(input_light_missing_pin, 1'b1);
        rd(8'hA2, 8'h6E);
        check(v, 8'h06);
        light_lost_in = 1'b0;
        laser_fail_in = 1'b0;
        ph(5);
        check(input_light_missing_pin, 1'b0);
        rd(8'hA2, 8'h6E);
        check(v, 8'h04);
        dis_drv = 1'b1;
        ph(5);
        dis_drv = 1'b0;
        ph(5);
        $display("t_los done");
    endtask : t_los
    task t_page;
        rd(8'hA2, 8'h6D);
        check({k, v}, 9'h000);
        rd(8'hA0, 8'h6E);
        check({k, v}, 9'h1FF);
        $display("t_page done");
    endtask : t_page
    initial
    begin
        n_errors      = 0;
        check_count   = 0;
        arst_n        = 1'b0;
        dis_drv       = 1'b0;
        dis_open      = 1'b1;
        scl_m         = 1'b1;
        sda_m         = 1'b1;
        laser_fail_in = 1'b0;
        eye_unsafe_in = 1'b0;
        light_lost_in = 1'b0;
        ph(6);
        check({laser_enable, fault_wire, input_light_missing_pin, sda_oe}, 4'h0);
        check({sda_out, laser_fault_out}, 2'b00);
        ph(6);
        arst_n = 1'b1;
        t_float;
        t_fault(1'b0);
        t_fault(1'b1);
        t_los;
        t_page;
        close_out;
    end
endmodule : test_optical_module_tx_control_status
`default_nettype wire
